// [eeh_ctrl.v]
`timescale 1ns/1ps
`include "eeh_regs.vh"

module eeh_ctrl #(
  parameter [`EEH_TW-1:0] PROG_CYC  = `EEH_WC_CYC,
  parameter [`EEH_TW-1:0] ERASE_CYC = `EEH_ERASE_CYC
) (
  // Clock and reset
  input  wire                  MCLK,
  input  wire                  RST_B,
  // Command port
  input  wire                  CMD_VALID,
  output wire                  CMD_READY,
  input  wire [`EEH_OPW-1:0]   CMD_OP,
  input  wire [`EEH_AW-1:0]    CMD_ADDR,
  input  wire [`EEH_DW-1:0]    CMD_DATA,
  // Mode levels
  input  wire                  PROTECT,
  input  wire                  POLL_TOGGLE,
  // Answer port
  output reg                   RSP_VALID,
  output reg  [`EEH_DW-1:0]    RSP_DATA,
  output reg                   RSP_FAIL,
  output wire                  BUSY,
  // Memory pins
  output reg  [`EEH_AW-1:0]    MEM_A,
  output reg                   MEM_CE_N,
  output reg                   MEM_OE_N,
  output reg                   MEM_WE_N,
  output reg                   MEM_OE_HV,
  input  wire [`EEH_DW-1:0]    MEM_DQ_IN,
  output reg  [`EEH_DW-1:0]    MEM_DQ_OUT,
  output reg                   MEM_DQ_OE_N
);
  localparam [9:0] S_IDLE  = 10'h001;
  localparam [9:0] S_WSET  = 10'h002;
  localparam [9:0] S_WLOW  = 10'h004;
  localparam [9:0] S_WHIGH = 10'h008;
  localparam [9:0] S_NEXT  = 10'h010;
  localparam [9:0] S_LAPSE = 10'h020;
  localparam [9:0] S_RACC  = 10'h040;
  localparam [9:0] S_RGAP  = 10'h080;
  localparam [9:0] S_ERASE = 10'h100;
  localparam [9:0] M_CE    = S_WSET | S_WLOW | S_WHIGH | S_NEXT | S_RACC | S_ERASE;
  localparam [9:0] M_DRV   = S_WSET | S_WLOW | S_WHIGH | S_NEXT;

  localparam [`EEH_TW-1:0] WP_END   = `EEH_WP_CYC - 1;
  localparam [`EEH_TW-1:0] WPH_END  = `EEH_WPH_CYC - 1;
  localparam [`EEH_TW-1:0] RD_END   = `EEH_ACC_CYC + `EEH_SYNC_CYC - 1;
  localparam [`EEH_TW-1:0] GAP_END  = `EEH_OEHP_CYC - 1;
  localparam [`EEH_TW-1:0] BLC_LIM  = `EEH_BLC_CYC;
  localparam [`EEH_TW-1:0] BLC_GRD  = `EEH_BLC_GUARD;
  localparam [`EEH_TW-1:0] T_ONE    = 1;
  localparam [2:0]         IDX_ONE  = 1;
  localparam [6:0]         CNT_ONE  = 1;

  // Lock command byte by sequence kind and index
  function [`EEH_AW+`EEH_DW-1:0] cmd_seq;
    input       dis;
    input [2:0] idx;
    begin
      case (idx)
        3'h0: cmd_seq = {`EEH_SEQ_A0, `EEH_SEQ_D0};
        3'h1: cmd_seq = {`EEH_SEQ_A1, `EEH_SEQ_D1};
        3'h3: cmd_seq = {`EEH_SEQ_A0, `EEH_SEQ_D_DIS3};
        3'h4: cmd_seq = {`EEH_SEQ_A1, `EEH_SEQ_D1};
        3'h5: cmd_seq = {`EEH_SEQ_A0, `EEH_SEQ_D_DIS5};
        default: cmd_seq = dis ? {`EEH_SEQ_A0, `EEH_SEQ_D0} : {`EEH_SEQ_A0, `EEH_SEQ_D_EN};
      endcase
    end
  endfunction

  reg  [9:0]               st_ff;
  reg  [9:0]               nxt_st;
  reg  [`EEH_TW-1:0]       tmr_ff;
  reg  [`EEH_TW-1:0]       win_ff;
  reg  [`EEH_TW-1:0]       prog_ff;
  reg  [2:0]               pre_idx_ff;
  reg  [2:0]               pre_len_ff;
  reg                      pre_dis_ff;
  reg                      load_ff;
  reg                      user_ff;
  reg  [6:0]               page_ff;
  reg  [6:0]               cnt_ff;
  reg  [`EEH_AW-1:0]       last_a_ff;
  reg  [`EEH_DW-1:0]       last_d_ff;
  reg                      poll_ff;
  reg                      fin_ff;
  reg                      tgl_prev_ff;
  reg                      tgl_have_ff;
  reg  [`EEH_DW-1:0]       dq_s1_ff;
  reg  [`EEH_DW-1:0]       dq_s2_ff;
  reg  [`EEH_DW-1:0]       dq_s3_ff;
  reg  [`EEH_DW-1:0]       dq_ff;
  reg                      f_pop;
  reg                      ld;
  reg                      ld_pre;
  reg                      ld_user;
  reg  [`EEH_AW+`EEH_DW-1:0] ld_word;
  reg                      rsp_go;
  reg                      poll_done;
  wire                     f_valid;
  wire [`EEH_FW-1:0]       f_data;
  wire [`EEH_OPW-1:0]      f_op;
  wire [`EEH_AW-1:0]       f_addr;
  wire [`EEH_DW-1:0]       f_dat;
  wire                     pre_pend;
  wire                     same_pg;
  wire                     use_tgl;
  wire                     timeout;
  wire                     f_dis;

  eeh_fifo #(
    .W  (`EEH_FW),
    .D  (`EEH_FIFO_DEPTH),
    .AW (`EEH_FIFO_AW)
  ) u_fifo (
    .clk       (MCLK),
    .rst_b     (RST_B),
    .in_valid  (CMD_VALID),
    .in_ready  (CMD_READY),
    .in_data   ({CMD_OP, CMD_ADDR, CMD_DATA}),
    .out_valid (f_valid),
    .out_ready (f_pop),
    .out_data  (f_data)
  );

  assign f_op     = f_data[`EEH_FW-1 -: `EEH_OPW];
  assign f_addr   = f_data[`EEH_AW+`EEH_DW-1 -: `EEH_AW];
  assign f_dat    = f_data[`EEH_DW-1:0];
  assign f_dis    = (f_op == `EEH_OP_LOCK_OFF);
  assign pre_pend = (pre_idx_ff < pre_len_ff);
  assign same_pg  = (f_op == `EEH_OP_LOAD) && (f_addr[`EEH_AW-1:`EEH_PAGE_LSB] == page_ff)
                    && (cnt_ff < `EEH_PAGE_BYTES);
  assign use_tgl  = POLL_TOGGLE | ~user_ff;
  assign timeout  = (prog_ff >= PROG_CYC);
  assign BUSY     = (st_ff != S_IDLE);

  always @* begin
    if (use_tgl) begin
      poll_done = tgl_have_ff && (dq_ff[`EEH_TGL_BIT] == tgl_prev_ff);
    end else begin
      poll_done = (dq_ff[`EEH_POLL_BIT] == last_d_ff[`EEH_POLL_BIT]);
    end
  end

  always @* begin
    nxt_st  = st_ff;
    f_pop   = 1'b0;
    ld      = 1'b0;
    ld_pre  = 1'b0;
    ld_user = 1'b0;
    ld_word = {f_addr, f_dat};
    rsp_go  = 1'b0;
    case (st_ff)
      S_IDLE: begin
        if (f_valid) begin
          case (f_op)
            `EEH_OP_READ: begin
              f_pop  = 1'b1;
              nxt_st = S_RACC;
            end
            `EEH_OP_LOAD: begin
              ld     = 1'b1;
              nxt_st = S_WSET;
              if (PROTECT) begin
                ld_pre  = 1'b1;
                ld_word = cmd_seq(1'b0, 3'h0);
              end else begin
                f_pop   = 1'b1;
                ld_user = 1'b1;
              end
            end
            `EEH_OP_LOCK_ON, `EEH_OP_LOCK_OFF: begin
              f_pop   = 1'b1;
              ld      = 1'b1;
              ld_pre  = 1'b1;
              ld_word = cmd_seq(f_dis, 3'h0);
              nxt_st  = S_WSET;
            end
            `EEH_OP_ERASE: begin
              f_pop  = 1'b1;
              nxt_st = S_ERASE;
            end
            default: begin
              f_pop = 1'b1;
            end
          endcase
        end
      end
      S_WSET: begin
        nxt_st = S_WLOW;
      end
      S_WLOW: begin
        if (tmr_ff == WP_END) begin
          nxt_st = S_WHIGH;
        end
      end
      S_WHIGH: begin
        if (tmr_ff == WPH_END) begin
          nxt_st = S_NEXT;
        end
      end
      S_NEXT: begin
        if (pre_pend) begin
          ld      = 1'b1;
          ld_pre  = 1'b1;
          ld_word = cmd_seq(pre_dis_ff, pre_idx_ff);
          nxt_st  = S_WSET;
        end else if (load_ff && f_valid && same_pg) begin
          f_pop   = 1'b1;
          ld      = 1'b1;
          ld_user = 1'b1;
          nxt_st  = S_WSET;
        end else if (!(load_ff && !f_valid && (win_ff < BLC_GRD))) begin
          nxt_st = S_LAPSE;
        end
      end
      S_LAPSE: begin
        if (win_ff > BLC_LIM) begin
          nxt_st = S_RACC;
        end
      end
      S_RACC: begin
        if (tmr_ff == RD_END) begin
          nxt_st = S_RGAP;
          rsp_go = ~poll_ff | poll_done | timeout;
        end
      end
      S_RGAP: begin
        if (tmr_ff == GAP_END) begin
          nxt_st = fin_ff ? S_IDLE : S_RACC;
        end
      end
      S_ERASE: begin
        if (tmr_ff == ERASE_CYC - T_ONE) begin
          nxt_st = S_RGAP;
          rsp_go = 1'b1;
        end
      end
      default: begin
        nxt_st = S_IDLE;
      end
    endcase
  end

  // Data pins pass three flops; a bit counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < `EEH_DW; gi = gi + 1) begin : g_dq
      always @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
          dq_ff[gi] <= 1'b0;
        end else if (dq_s2_ff[gi] == dq_s3_ff[gi]) begin
          dq_ff[gi] <= dq_s3_ff[gi];
        end
      end
    end
  endgenerate

  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      dq_s1_ff <= {`EEH_DW{1'b0}};
      dq_s2_ff <= {`EEH_DW{1'b0}};
      dq_s3_ff <= {`EEH_DW{1'b0}};
    end else begin
      dq_s1_ff <= MEM_DQ_IN;
      dq_s2_ff <= dq_s1_ff;
      dq_s3_ff <= dq_s2_ff;
    end
  end

  // Pins follow the next state, so strobes change together with the state
  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      MEM_CE_N    <= 1'b1;
      MEM_OE_N    <= 1'b1;
      MEM_WE_N    <= 1'b1;
      MEM_OE_HV   <= 1'b0;
      MEM_DQ_OE_N <= 1'b1;
    end else begin
      MEM_CE_N    <= ~|(nxt_st & M_CE);
      MEM_OE_N    <= ~|(nxt_st & S_RACC);
      MEM_WE_N    <= ~|(nxt_st & (S_WLOW | S_ERASE));
      MEM_OE_HV   <= |(nxt_st & S_ERASE);
      MEM_DQ_OE_N <= ~|(nxt_st & M_DRV);
    end
  end

  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      st_ff       <= S_IDLE;
      tmr_ff      <= {`EEH_TW{1'b0}};
      win_ff      <= {`EEH_TW{1'b0}};
      prog_ff     <= {`EEH_TW{1'b0}};
      pre_idx_ff  <= 3'h0;
      pre_len_ff  <= 3'h0;
      pre_dis_ff  <= 1'b0;
      load_ff     <= 1'b0;
      user_ff     <= 1'b0;
      page_ff     <= 7'h00;
      cnt_ff      <= 7'h00;
      last_a_ff   <= {`EEH_AW{1'b0}};
      last_d_ff   <= {`EEH_DW{1'b0}};
      poll_ff     <= 1'b0;
      fin_ff      <= 1'b0;
      tgl_prev_ff <= 1'b0;
      tgl_have_ff <= 1'b0;
      MEM_A       <= {`EEH_AW{1'b0}};
      MEM_DQ_OUT  <= {`EEH_DW{1'b0}};
      RSP_VALID   <= 1'b0;
      RSP_DATA    <= {`EEH_DW{1'b0}};
      RSP_FAIL    <= 1'b0;
    end else begin
      st_ff     <= nxt_st;
      tmr_ff    <= (nxt_st != st_ff) ? {`EEH_TW{1'b0}} : tmr_ff + T_ONE;
      RSP_VALID <= rsp_go;
      if (st_ff == S_IDLE) begin
        poll_ff     <= 1'b0;
        fin_ff      <= 1'b0;
        user_ff     <= 1'b0;
        cnt_ff      <= 7'h00;
        pre_idx_ff  <= 3'h0;
        pre_len_ff  <= 3'h0;
        pre_dis_ff  <= f_dis;
        load_ff     <= (f_op == `EEH_OP_LOAD);
        page_ff     <= f_addr[`EEH_AW-1:`EEH_PAGE_LSB];
        MEM_A       <= f_addr;
        if (f_op == `EEH_OP_LOAD) begin
          pre_len_ff <= PROTECT ? `EEH_SEQ_EN_LEN : 3'h0;
        end else if (f_op == `EEH_OP_LOCK_ON) begin
          pre_len_ff <= `EEH_SEQ_EN_LEN;
        end else if (f_op == `EEH_OP_LOCK_OFF) begin
          pre_len_ff <= `EEH_SEQ_DIS_LEN;
        end
      end
      if (ld) begin
        MEM_A      <= ld_word[`EEH_AW+`EEH_DW-1 -: `EEH_AW];
        MEM_DQ_OUT <= ld_word[`EEH_DW-1:0];
        last_a_ff  <= ld_word[`EEH_AW+`EEH_DW-1 -: `EEH_AW];
        last_d_ff  <= ld_word[`EEH_DW-1:0];
        win_ff     <= {`EEH_TW{1'b0}};
      end else if (win_ff <= BLC_LIM) begin
        win_ff <= win_ff + T_ONE;
      end
      if (ld_pre) begin
        pre_idx_ff <= pre_idx_ff + IDX_ONE;
      end
      if (ld_user) begin
        user_ff <= 1'b1;
        cnt_ff  <= cnt_ff + CNT_ONE;
      end
      if (st_ff == S_NEXT) begin
        prog_ff <= {`EEH_TW{1'b0}};
      end else if (!timeout) begin
        prog_ff <= prog_ff + T_ONE;
      end
      if ((st_ff == S_LAPSE) && (nxt_st == S_RACC)) begin
        poll_ff     <= 1'b1;
        tgl_have_ff <= 1'b0;
        MEM_A       <= last_a_ff;
      end
      if ((st_ff == S_RACC) && (nxt_st == S_RGAP)) begin
        tgl_prev_ff <= dq_ff[`EEH_TGL_BIT];
        tgl_have_ff <= 1'b1;
        fin_ff      <= rsp_go;
      end
      if (st_ff == S_ERASE) begin
        fin_ff <= 1'b1;
      end
      if (rsp_go) begin
        RSP_DATA <= dq_ff;
        RSP_FAIL <= poll_ff & ~poll_done & timeout;
      end
    end
  end
endmodule // eeh_ctrl

// [eeh_regs.vh]
`ifndef EEH_REGS_VH
`define EEH_REGS_VH

// Clock and pin timing
`define EEH_CLK_NS       50
`define EEH_T_WP_NS      100
`define EEH_T_WPH_NS     50
`define EEH_T_ACC_NS     120
`define EEH_T_OEHP_NS    150
`define EEH_T_BLC_US     150
`define EEH_T_WC_MS      2
`define EEH_CEIL(t)      (((t) + `EEH_CLK_NS - 1) / `EEH_CLK_NS)
`define EEH_WP_CYC       `EEH_CEIL(`EEH_T_WP_NS)
`define EEH_WPH_CYC      `EEH_CEIL(`EEH_T_WPH_NS)
`define EEH_ACC_CYC      `EEH_CEIL(`EEH_T_ACC_NS)
`define EEH_OEHP_CYC     `EEH_CEIL(`EEH_T_OEHP_NS)
// Three pin flops plus the agreement stage
`define EEH_SYNC_CYC     4
// Longest window rounds down
`define EEH_BLC_CYC      ((`EEH_T_BLC_US * 1000) / `EEH_CLK_NS)
// Stop waiting for more page bytes at half the window
`define EEH_BLC_GUARD    (`EEH_BLC_CYC / 2)
`define EEH_WC_CYC       ((`EEH_T_WC_MS * 1000000) / `EEH_CLK_NS)
`define EEH_ERASE_CYC    200000

// Widths and layout
`define EEH_AW           13
`define EEH_DW           8
`define EEH_OPW          3
`define EEH_FW           24
`define EEH_TW           24
`define EEH_FIFO_DEPTH   16
`define EEH_FIFO_AW      4
`define EEH_PAGE_BYTES   7'h40
`define EEH_PAGE_LSB     6
`define EEH_POLL_BIT     7
`define EEH_TGL_BIT      6

// Command codes
`define EEH_OP_READ      3'h0
`define EEH_OP_LOAD      3'h1
`define EEH_OP_LOCK_ON   3'h2
`define EEH_OP_LOCK_OFF  3'h3
`define EEH_OP_ERASE     3'h4

// Lock command sequences, values arbitrary
`define EEH_SEQ_EN_LEN   3'h3
`define EEH_SEQ_DIS_LEN  3'h6
`define EEH_SEQ_A0       13'h0AA1
`define EEH_SEQ_A1       13'h0552
`define EEH_SEQ_D0       8'h11
`define EEH_SEQ_D1       8'h22
`define EEH_SEQ_D_EN     8'h33
`define EEH_SEQ_D_DIS3   8'h44
`define EEH_SEQ_D_DIS5   8'h55

`endif

// [eeh_fifo.v]
`timescale 1ns/1ps
`include "eeh_regs.vh"

module eeh_fifo #(
  parameter W  = `EEH_FW,
  parameter D  = `EEH_FIFO_DEPTH,
  parameter AW = `EEH_FIFO_AW
) (
  // Clock and reset
  input  wire         clk,
  input  wire         rst_b,
  // Fill side
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  // Drain side
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);
  localparam [AW:0]   FULL = D;
  localparam [AW:0]   ONE_C = 1;
  localparam [AW-1:0] ONE_P = 1;

  reg [W-1:0]  mem [0:D-1];
  reg [AW-1:0] wr_ff;
  reg [AW-1:0] rd_ff;
  reg [AW:0]   cnt_ff;
  wire         push;
  wire         pop;

  assign in_ready  = (cnt_ff != FULL);
  assign out_valid = (cnt_ff != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ff];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ff] <= in_data;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ff  <= {AW{1'b0}};
      rd_ff  <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ff <= wr_ff + ONE_P;
      end
      if (pop) begin
        rd_ff <= rd_ff + ONE_P;
      end
      if (push & ~pop) begin
        cnt_ff <= cnt_ff + ONE_C;
      end else if (pop & ~push) begin
        cnt_ff <= cnt_ff - ONE_C;
      end
    end
  end
endmodule // eeh_fifo

// [eeh_ctrl_assertions.sv]
`timescale 1ns/1ps
`include "eeh_regs.vh"
module eeh_ctrl_chk #(
  parameter [`EEH_TW-1:0] PROG_CYC  = `EEH_WC_CYC,
  parameter [`EEH_TW-1:0] ERASE_CYC = `EEH_ERASE_CYC
) (
  // Clock and reset
  input wire               MCLK,
  input wire               RST_B,
  // Command side
  input wire               CMD_VALID,
  input wire               CMD_READY,
  input wire               RSP_VALID,
  input wire               RSP_FAIL,
  // Memory pins
  input wire [`EEH_AW-1:0] MEM_A,
  input wire               MEM_CE_N,
  input wire               MEM_OE_N,
  input wire               MEM_WE_N,
  input wire               MEM_OE_HV,
  input wire [`EEH_DW-1:0] MEM_DQ_OUT,
  input wire               MEM_DQ_OE_N
);
  localparam int BLC = `EEH_BLC_CYC;
  reg [15:0]        gap_ff;
  reg [`EEH_TW-1:0] hv_ff;
  // Select-low cycles without a strobe, and length of the erase level
  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      gap_ff <= 16'h0000;
      hv_ff  <= {`EEH_TW{1'b0}};
    end else begin
      gap_ff <= (MEM_CE_N || !MEM_WE_N) ? 16'h0000 : gap_ff + 16'h0001;
      hv_ff  <= MEM_OE_HV ? hv_ff + 1'b1 : {`EEH_TW{1'b0}};
    end
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  a_read_gate: assert property (!MEM_OE_N |-> MEM_WE_N && MEM_DQ_OE_N && !MEM_CE_N)
    else $error("gate low with strobe or host drive");
  a_read_width: assert property ($fell(MEM_OE_N) |-> !MEM_OE_N [*7] ##1 MEM_OE_N)
    else $error("read access length wrong");
  a_gate_gap: assert property ($rose(MEM_OE_N) |-> MEM_OE_N [*3])
    else $error("gate high gap too short");
  a_write_strobe: assert property ($fell(MEM_WE_N) && !MEM_OE_HV |-> !MEM_WE_N [*2] ##1 MEM_WE_N)
    else $error("write strobe width wrong");
  a_write_data: assert property (!MEM_WE_N && !MEM_OE_HV |->
    !MEM_DQ_OE_N && $stable(MEM_A) && $stable(MEM_DQ_OUT))
    else $error("address or data moved under strobe");
  a_write_gate: assert property (!MEM_WE_N |-> MEM_OE_N && !MEM_CE_N)
    else $error("gate low during write");
  a_standby_quiet: assert property (MEM_CE_N |-> MEM_WE_N && MEM_OE_N && !MEM_OE_HV)
    else $error("strobes active while deselected");
  a_erase_pins: assert property (MEM_OE_HV |-> !MEM_CE_N && !MEM_WE_N && MEM_DQ_OE_N)
    else $error("erase pin levels wrong");
  a_erase_len: assert property ($fell(MEM_OE_HV) |-> hv_ff == ERASE_CYC)
    else $error("erase level length wrong");
  a_load_window: assert property (gap_ff < BLC)
    else $error("byte load window exceeded");
  a_rsp_pulse: assert property (RSP_VALID |=> !RSP_VALID)
    else $error("answer longer than one cycle");
  c_read: cover property ($fell(MEM_OE_N));
  c_erase: cover property ($fell(MEM_OE_HV));
  c_fail: cover property (RSP_VALID && RSP_FAIL);
  c_full: cover property (CMD_VALID && !CMD_READY);
endmodule // eeh_ctrl_chk

// [eeh_mem_model.sv]
`timescale 1ns/1ps
`include "eeh_regs.vh"
module eeh_mem_model #(
  parameter       WIN   = 1600,
  parameter [7:0] BLANK = 8'hFF
) (
  // Timebase
  input  wire        clk,
  // Device pins
  input  wire [12:0] a,
  input  wire        ce_n,
  input  wire        oe_n,
  input  wire        we_n,
  input  wire        oe_hv,
  input  wire [7:0]  host_dq,
  input  wire        host_dq_oe_n,
  // Programming time in clocks
  input  wire [23:0] prog_len,
  // Resolved data wire
  output wire [7:0]  dq
);
  reg [7:0]  mem [0:8191];
  reg [12:0] ba [0:69];
  reg [7:0]  bd [0:69];
  reg [12:0] cap_a;
  reg [7:0]  cap_d;
  reg [7:0]  ld;
  reg [7:0]  last;
  reg        pend, lock, tgl, oe_d, en, dis, wr;
  integer    n, win, busy, i, s;
  wire       drive = !ce_n && !oe_n && we_n && !oe_hv;
  wire [7:0] rd = (busy != 0) ? {~ld[7], tgl, ld[5:0]} : mem[a];
  // drive only in read mode; a released wire drifts
  assign dq = !host_dq_oe_n ? host_dq : drive ? rd : ~last;
  initial begin
    for (i = 0; i < 8192; i++) mem[i] = BLANK;
    n = 0;
    win = 0;
    busy = 0;
    pend = 0;
    lock = 0;
    tgl = 0;
    oe_d = 1;
    last = 8'h00;
  end
  always @(posedge clk) begin
    oe_d <= oe_n;
    last <= dq;
    // capture under strobe, latch into page buffer on release
    if (!ce_n && !we_n && oe_n && !oe_hv) begin
      cap_a <= a;
      cap_d <= dq;
      pend <= 1'b1;
    end
    // window lapse starts programming; no loads while busy
    if (we_n && pend) begin
      pend <= 1'b0;
      if (busy == 0 && n < 70) begin
        ba[n] <= cap_a;
        bd[n] <= cap_d;
        ld <= cap_d;
        n <= n + 1;
        win <= WIN;
      end
    end else if (win > 1) win <= win - 1;
    else if (win == 1) begin
      win <= 0;
      busy <= prog_len;
    end
    // status bit flips on each read start while busy
    if (oe_d && !oe_n && !ce_n && busy != 0) tgl <= ~tgl;
    // lock state and guarded commit at end of programming
    if (busy > 1) busy <= busy - 1;
    else if (busy == 1) begin
      busy <= 0;
      n <= 0;
      en = n >= 3 && bd[0] == `EEH_SEQ_D0 && bd[2] == `EEH_SEQ_D_EN;
      dis = n >= 6 && bd[3] == `EEH_SEQ_D_DIS3 && bd[5] == `EEH_SEQ_D_DIS5;
      s = en ? 3 : dis ? 6 : 0;
      if (dis) lock <= 1'b0;
      else if (en) lock <= 1'b1;
      wr = en || dis || !lock;
      for (i = s; i < n; i++) if (wr) mem[ba[i]] <= bd[i];
    end
    if (!ce_n && !we_n && oe_hv) for (i = 0; i < 8192; i++) mem[i] <= BLANK;
  end
endmodule // eeh_mem_model

// [testbench.sv]
`timescale 1ns/1ps
`include "eeh_regs.vh"
module testbench;
  // Host patience must outlast the byte window wait before the first poll
  localparam [`EEH_TW-1:0] PROG_CYC  = 8000;
  localparam [`EEH_TW-1:0] ERASE_CYC = 50;
  reg         MCLK, RST_B, CMD_VALID, PROTECT, POLL_TOGGLE, saw_full;
  reg [2:0]   CMD_OP;
  reg [12:0]  CMD_ADDR;
  reg [7:0]   CMD_DATA;
  reg [23:0]  prog_len;
  reg [35:0]  rows [0:14];
  reg [35:0]  r;
  wire        CMD_READY, RSP_VALID, RSP_FAIL, BUSY;
  wire        MEM_CE_N, MEM_OE_N, MEM_WE_N, MEM_OE_HV, MEM_DQ_OE_N;
  wire [7:0]  RSP_DATA, MEM_DQ_OUT, dq;
  wire [12:0] MEM_A;
  integer     error_cnt, checks_done, rsp_cnt, base, i;
  eeh_ctrl #(.PROG_CYC(PROG_CYC), .ERASE_CYC(ERASE_CYC)) dut (
    .MCLK(MCLK), .RST_B(RST_B), .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY),
    .CMD_OP(CMD_OP), .CMD_ADDR(CMD_ADDR), .CMD_DATA(CMD_DATA), .PROTECT(PROTECT),
    .POLL_TOGGLE(POLL_TOGGLE), .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA),
    .RSP_FAIL(RSP_FAIL), .BUSY(BUSY), .MEM_A(MEM_A), .MEM_CE_N(MEM_CE_N),
    .MEM_OE_N(MEM_OE_N), .MEM_WE_N(MEM_WE_N), .MEM_OE_HV(MEM_OE_HV),
    .MEM_DQ_IN(dq), .MEM_DQ_OUT(MEM_DQ_OUT), .MEM_DQ_OE_N(MEM_DQ_OE_N));
  eeh_mem_model u_dev (.clk(MCLK), .a(MEM_A), .ce_n(MEM_CE_N), .oe_n(MEM_OE_N),
    .we_n(MEM_WE_N), .oe_hv(MEM_OE_HV), .host_dq(MEM_DQ_OUT),
    .host_dq_oe_n(MEM_DQ_OE_N), .prog_len(prog_len), .dq(dq));
  initial begin
    MCLK = 1'b0;
    forever #25 MCLK = ~MCLK;
  end
  always @(posedge MCLK) if (RSP_VALID === 1'b1) rsp_cnt <= rsp_cnt + 1;
  task check(input [31:0] seen, input [31:0] exp);
    begin
      checks_done++;
      if (seen !== exp) begin
        error_cnt++;
        $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task final_report;
    begin
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  // Offer one command, hold it until taken; lower valid only after the last
  task push(input [2:0] op, input [12:0] ad, input [7:0] d, input last);
    reg     rdy;
    integer n;
    begin
      CMD_VALID = 1'b1;
      CMD_OP = op;
      CMD_ADDR = ad;
      CMD_DATA = d;
      rdy = 1'b0;
      for (n = 0; n < 5000 && !rdy; n++) begin
        rdy = CMD_READY;
        if (!rdy) saw_full = 1'b1;
        @(posedge MCLK);
        #1;
      end
      if (!rdy) begin
        error_cnt++;
        final_report;
      end
      if (last) CMD_VALID = 1'b0;
    end
  endtask
  task wait_rsp(input [7:0] exp, input fail, input chk);
    integer n;
    begin
      n = 0;
      while (RSP_VALID !== 1'b1 && n < 20000) begin
        @(posedge MCLK);
        #1;
        n++;
      end
      if (n >= 20000) begin
        error_cnt++;
        final_report;
      end
      check(RSP_FAIL, fail);
      if (chk) check(RSP_DATA, exp);
    end
  endtask
  task idle_chk;
    check({MEM_CE_N, MEM_OE_N, MEM_WE_N, MEM_DQ_OE_N, MEM_OE_HV, BUSY, RSP_VALID,
      CMD_READY}, 8'hF1);
  endtask
  initial begin
    error_cnt = 0;
    checks_done = 0;
    rsp_cnt = 0;
    saw_full = 1'b0;
    RST_B = 1'b0;
    CMD_VALID = 1'b0;
    CMD_OP = 3'h0;
    CMD_ADDR = 13'h0000;
    CMD_DATA = 8'h00;
    PROTECT = 1'b0;
    POLL_TOGGLE = 1'b0;
    prog_len = 24'd400;
    // op, address, data, protect, toggle, expected data, fail, data checked
    rows = '{
      {`EEH_OP_LOAD, 13'h0041, 8'hA5, 2'b00, 8'hA5, 2'b01},
      {`EEH_OP_READ, 13'h0041, 8'h00, 2'b00, 8'hA5, 2'b01},
      {`EEH_OP_LOAD, 13'h1F80, 8'h3C, 2'b01, 8'h3C, 2'b01},
      {`EEH_OP_READ, 13'h1F80, 8'h00, 2'b00, 8'h3C, 2'b01},
      {`EEH_OP_READ, 13'h1FFF, 8'h00, 2'b00, 8'hFF, 2'b01},
      {`EEH_OP_LOCK_ON, 13'h0000, 8'h00, 2'b00, 8'h00, 2'b00},
      {`EEH_OP_LOAD, 13'h0041, 8'h5A, 2'b00, 8'h00, 2'b10},
      {`EEH_OP_READ, 13'h0041, 8'h00, 2'b00, 8'hA5, 2'b01},
      {`EEH_OP_LOAD, 13'h0041, 8'hC3, 2'b10, 8'hC3, 2'b01},
      {`EEH_OP_READ, 13'h0041, 8'h00, 2'b00, 8'hC3, 2'b01},
      {`EEH_OP_LOCK_OFF, 13'h0000, 8'h00, 2'b00, 8'h00, 2'b00},
      {`EEH_OP_LOAD, 13'h0041, 8'h96, 2'b00, 8'h96, 2'b01},
      {`EEH_OP_READ, 13'h0041, 8'h00, 2'b00, 8'h96, 2'b01},
      {`EEH_OP_ERASE, 13'h0000, 8'h00, 2'b00, 8'h00, 2'b00},
      {`EEH_OP_READ, 13'h0041, 8'h00, 2'b00, 8'hFF, 2'b01}};
    repeat (10) @(posedge MCLK);
    #1;
    idle_chk;
    RST_B = 1'b1;
    for (i = 0; i < 15; i++) begin
      r = rows[i];
      PROTECT = r[11];
      POLL_TOGGLE = r[10];
      push(r[35:33], r[32:20], r[19:12], 1'b1);
      wait_rsp(r[9:2], r[1], r[0]);
    end
    PROTECT = 1'b0;
    POLL_TOGGLE = 1'b0;
    // Let the last answer reach the counter before taking the base
    @(posedge MCLK);
    #1;
    // Full page back to back: queue refuses, one answer for the page
    base = rsp_cnt;
    for (i = 0; i < 64; i++) push(`EEH_OP_LOAD, 13'h0080 + i[12:0], i[7:0] ^ 8'h3C, i == 63);
    wait_rsp(8'h03, 1'b0, 1'b1);
    check(saw_full, 1'b1);
    push(`EEH_OP_READ, 13'h0080, 8'h00, 1'b1);
    wait_rsp(8'h3C, 1'b0, 1'b1);
    push(`EEH_OP_READ, 13'h00BF, 8'h00, 1'b1);
    wait_rsp(8'h03, 1'b0, 1'b1);
    @(posedge MCLK);
    #1;
    check(rsp_cnt - base, 3);
    // Device slower than the host's patience
    prog_len = 24'd9000;
    push(`EEH_OP_LOAD, 13'h0100, 8'h77, 1'b1);
    wait_rsp(8'h00, 1'b1, 1'b0);
    repeat (6000) @(posedge MCLK);
    #1;
    prog_len = 24'd400;
    push(`EEH_OP_READ, 13'h0100, 8'h00, 1'b1);
    wait_rsp(8'h77, 1'b0, 1'b1);
    // Reset in the middle of a read
    push(`EEH_OP_READ, 13'h0041, 8'h00, 1'b1);
    repeat (3) @(posedge MCLK);
    #1;
    RST_B = 1'b0;
    #1;
    idle_chk;
    repeat (10) @(posedge MCLK);
    #1;
    RST_B = 1'b1;
    push(`EEH_OP_READ, 13'h0041, 8'h00, 1'b1);
    wait_rsp(8'hFF, 1'b0, 1'b1);
    final_report;
  end
endmodule // testbench

bind eeh_ctrl eeh_ctrl_chk #(.PROG_CYC(PROG_CYC), .ERASE_CYC(ERASE_CYC)) u_chk (
  .MCLK(MCLK), .RST_B(RST_B), .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY),
  .RSP_VALID(RSP_VALID), .RSP_FAIL(RSP_FAIL), .MEM_A(MEM_A), .MEM_CE_N(MEM_CE_N),
  .MEM_OE_N(MEM_OE_N), .MEM_WE_N(MEM_WE_N), .MEM_OE_HV(MEM_OE_HV),
  .MEM_DQ_OUT(MEM_DQ_OUT), .MEM_DQ_OE_N(MEM_DQ_OE_N));
